// ==== src/cbm_master.sv ====
// cpu-side output stage of the tightly coupled coprocessor bus
// Notes on behaviour
// - cop: dest on A, sources on B, C
// - word uses A; double: A=reg+1, B=reg
// - sysreg moves: index low nibble on A
// - flushed high cycle after pipeline flush
// - data-stage address exception causes flush
// - stalled high cycle after stall, else low
// - two 32-bit write buses A and B
// - word data on A only; B ignored
// - double: high word A, low word B
// - cpno carries index high nibble or unit
// - low ready stalls; bus outputs held meanwhile
// - stalled high after any low ready
module cbm_master
    import cbm_pkg::*;
(
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic req_valid_i,
    output logic req_ready_o,
    input wire cbm_req_t req_i,
    input wire logic ls_stall_i,
    input wire logic ls_flush_i,
    input wire logic addr_exc_i,
    input wire logic bus_ready_i,
    output logic [CMD_W-1:0] bus_cmd_o,
    output logic [REG_W-1:0] bus_cpno_o,
    output logic [REG_W-1:0] bus_rega_o,
    output logic [REG_W-1:0] bus_regb_o,
    output logic [REG_W-1:0] bus_regc_o,
    output logic [DATA_W-1:0] bus_wdataa_o,
    output logic [DATA_W-1:0] bus_wdatab_o,
    output logic cpu_flushed_o,
    output logic cpu_stalled_o
);
    logic buf_in_ready;
    logic buf_valid;
    logic [$bits(cbm_req_t)-1:0] buf_raw;
    cbm_req_t head;
    cbm_bus_t next_bus;
    cbm_bus_t bus;
    logic [DATA_W-1:0] data_hi;
    logic [DATA_W-1:0] data_lo;

    // pipeline stalls on slave back-pressure or its own stall
    wire stall_now = ls_stall_i || !bus_ready_i;
    wire flush_now = ls_flush_i || addr_exc_i;
    wire advance = !stall_now;

    cbm_skid #(
        .WIDTH($bits(cbm_req_t))
    ) u_buf (
        .clk_i(clk_i),
        .reset_i(reset_i),
        .in_valid_i(req_valid_i),
        .in_ready_o(buf_in_ready),
        .in_data_i(req_i),
        .out_valid_o(buf_valid),
        .out_ready_i(advance),
        .out_data_o(buf_raw)
    );

    assign req_ready_o = buf_in_ready;
    assign head = cbm_req_t'(buf_raw);
    assign data_hi = head.data[63:32];
    assign data_lo = head.data[31:0];

    always_comb begin
        next_bus = '0;
        next_bus.cmd = CMD_NOP;
        if (buf_valid && !flush_now) begin
            next_bus.cmd = head.cmd;
            next_bus.cpno = head.cpno;
            unique case (head.kind)
                CBM_COP: begin
                    next_bus.rega = head.dest_unit_reg;
                    next_bus.regb = head.first_src_reg;
                    next_bus.regc = head.second_src_reg;
                end
                CBM_WORD_WR: begin
                    next_bus.rega = head.dest_unit_reg;
                    next_bus.wdataa = data_lo;
                end
                CBM_DBL_WR: begin
                    next_bus.rega = REG_W'(head.dest_unit_reg + REG_ONE);
                    next_bus.regb = head.dest_unit_reg;
                    next_bus.wdataa = data_hi;
                    next_bus.wdatab = data_lo;
                end
                CBM_WORD_RD: begin
                    next_bus.rega = head.source_unit_reg;
                end
                CBM_DBL_RD: begin
                    next_bus.rega = REG_W'(head.source_unit_reg + REG_ONE);
                    next_bus.regb = head.source_unit_reg;
                end
                CBM_SYSREG: begin
                    next_bus.rega = head.sysreg_index[SYS_LO_MSB:0];
                    next_bus.cpno = head.sysreg_index[7:SYS_HI_LSB];
                    next_bus.wdataa = data_lo;
                end
                default: begin
                    next_bus.cmd = CMD_NOP;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            bus <= '0;
        end else if (advance) begin
            bus <= next_bus;
        end
    end

    // one-cycle-late status registers
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            cpu_flushed_o <= 1'b0;
            cpu_stalled_o <= 1'b0;
        end else begin
            cpu_flushed_o <= flush_now;
            cpu_stalled_o <= stall_now;
        end
    end

    assign bus_cmd_o = bus.cmd;
    assign bus_cpno_o = bus.cpno;
    assign bus_rega_o = bus.rega;
    assign bus_regb_o = bus.regb;
    assign bus_regc_o = bus.regc;
    assign bus_wdataa_o = bus.wdataa;
    assign bus_wdatab_o = bus.wdatab;

    AST_FLUSH_LATE: assert property (@(posedge clk_i) disable iff (reset_i)
        flush_now |=> cpu_flushed_o) else $error("flushed not raised after flush");
    AST_EXC_FLUSH: assert property (@(posedge clk_i) disable iff (reset_i)
        addr_exc_i |=> cpu_flushed_o) else $error("address exception did not flush");
    AST_STALL_TRACK: assert property (@(posedge clk_i) disable iff (reset_i)
        ##1 cpu_stalled_o == $past(stall_now)) else $error("stalled not one cycle late");
    AST_READY_LOW: assert property (@(posedge clk_i) disable iff (reset_i)
        !bus_ready_i |=> cpu_stalled_o) else $error("stalled low after ready low");
    AST_HOLD: assert property (@(posedge clk_i) disable iff (reset_i)
        stall_now |=> $stable(bus_cmd_o) && $stable(bus_cpno_o) && $stable(bus_rega_o)
            && $stable(bus_regb_o) && $stable(bus_regc_o) && $stable(bus_wdataa_o)
            && $stable(bus_wdatab_o))
        else $error("bus changed during stall");
    AST_DBL_REG: assert property (@(posedge clk_i) disable iff (reset_i)
        advance && !flush_now && buf_valid && head.kind == CBM_DBL_WR
        |=> bus_rega_o == bus_regb_o + REG_ONE) else $error("double register pair wrong");
    AST_DBL_DATA: assert property (@(posedge clk_i) disable iff (reset_i)
        advance && !flush_now && buf_valid && head.kind == CBM_DBL_WR
        |=> {bus_wdataa_o, bus_wdatab_o} == $past(head.data)) else $error("double data order");
    AST_COP_REGS: assert property (@(posedge clk_i) disable iff (reset_i)
        advance && !flush_now && buf_valid && head.kind == CBM_COP
        |=> {bus_rega_o, bus_regb_o, bus_regc_o} == {$past(head.dest_unit_reg),
            $past(head.first_src_reg), $past(head.second_src_reg)})
        else $error("cop operands wrong");
    AST_SYS_SPLIT: assert property (@(posedge clk_i) disable iff (reset_i)
        advance && !flush_now && buf_valid && head.kind == CBM_SYSREG
        |=> {bus_cpno_o, bus_rega_o} == $past(head.sysreg_index)) else $error("sysreg split");
endmodule // cbm_master

// ==== src/cbm_pkg.sv ====
// package for the coprocessor bus master output block
package cbm_pkg;
    localparam int REG_W = 4;
    localparam int DATA_W = 32;
    localparam int CMD_W = 8;
    localparam logic [CMD_W-1:0] CMD_NOP = 8'h00;
    localparam logic [CMD_W-1:0] CMD_WRITE_W = 8'h01;
    localparam logic [CMD_W-1:0] CMD_WRITE_D = 8'h02;
    localparam logic [CMD_W-1:0] CMD_READ_W = 8'h03;
    localparam logic [CMD_W-1:0] CMD_READ_D = 8'h04;
    localparam logic [CMD_W-1:0] CMD_MTSR = 8'h05;
    localparam logic [CMD_W-1:0] CMD_MFSR = 8'h06;
    localparam logic [CMD_W-1:0] CMD_MTDR = 8'h07;
    localparam logic [CMD_W-1:0] CMD_MFDR = 8'h08;
    localparam int COP_BIT = 7;
    localparam int SYS_LO_MSB = 3;
    localparam int SYS_HI_LSB = 4;
    localparam logic [REG_W-1:0] REG_ONE = 4'h1;

    typedef enum logic [2:0] {
        CBM_COP,
        CBM_WORD_WR,
        CBM_DBL_WR,
        CBM_WORD_RD,
        CBM_DBL_RD,
        CBM_SYSREG
    } cbm_kind_t;

    // request from the load/store pipeline
    typedef struct packed {
        cbm_kind_t kind;
        logic [CMD_W-1:0] cmd;
        logic [REG_W-1:0] cpno;
        logic [REG_W-1:0] dest_unit_reg;
        logic [REG_W-1:0] source_unit_reg;
        logic [REG_W-1:0] first_src_reg;
        logic [REG_W-1:0] second_src_reg;
        logic [7:0] sysreg_index;
        logic [63:0] data;
    } cbm_req_t;

    // bus-side word
    typedef struct packed {
        logic [CMD_W-1:0] cmd;
        logic [REG_W-1:0] cpno;
        logic [REG_W-1:0] rega;
        logic [REG_W-1:0] regb;
        logic [REG_W-1:0] regc;
        logic [DATA_W-1:0] wdataa;
        logic [DATA_W-1:0] wdatab;
    } cbm_bus_t;
endpackage

// ==== src/cbm_skid.sv ====
// two-entry buffer with valid/ready on both sides
module cbm_skid
    import cbm_pkg::*;
#(
    parameter int WIDTH = 8
) (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);
    logic [WIDTH-1:0] mem [2];
    logic rd_ptr;
    logic wr_ptr;
    logic [1:0] count;
    logic [1:0] next_count;
    logic room;
    wire push = in_valid_i && in_ready_o;
    wire pop = out_valid_o && out_ready_i;

    // ready comes from a flop so the upstream sees no compare path
    assign in_ready_o = room;
    assign out_valid_o = (count != 2'h0);
    assign out_data_o = mem[rd_ptr];
    assign next_count = 2'(count + {1'b0, push} - {1'b0, pop});

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            rd_ptr <= 1'b0;
            wr_ptr <= 1'b0;
            count <= 2'h0;
            room <= 1'b1;
        end else begin
            if (push) begin
                wr_ptr <= ~wr_ptr;
            end
            if (pop) begin
                rd_ptr <= ~rd_ptr;
            end
            count <= next_count;
            room <= (next_count != 2'h2);
        end
    end

    always_ff @(posedge clk_i) begin
        if (push) begin
            mem[wr_ptr] <= in_data_i;
        end
    end
endmodule // cbm_skid

// ==== test/cbm_slave_model.sv ====
// partner model: coprocessor slave that can stall cop operations
module cbm_slave_model
    import cbm_pkg::*;
(
    input wire logic clk_i,
    input wire logic slow_i,
    input wire logic [CMD_W-1:0] bus_cmd_i,
    input wire logic cpu_stalled_i,
    input wire logic cpu_flushed_i,
    output logic bus_ready_o,
    output int ops_o
);
    logic [1:0] wait_cnt = 2'h0;
    int ops = 0;
    // write bus B is never looked at, so word transfers need no defined value there
    assign ops_o = ops;
    // a slow slave pulls ready low for two cycles while a cop opcode stands
    assign bus_ready_o = !(slow_i && bus_cmd_i[COP_BIT] && wait_cnt < 2'h2);
    always_ff @(posedge clk_i) begin
        wait_cnt <= bus_ready_o ? 2'h0 : wait_cnt + 2'h1;
        // opcode held across stall cycles runs once; nothing taken after a flush
        if (bus_cmd_i[COP_BIT] && !cpu_stalled_i && !cpu_flushed_i) begin
            ops <= ops + 1;
        end
    end
endmodule // cbm_slave_model

// ==== test/tb_coprocessor_bus_master_outputs.sv ====
// self-checking bench for the coprocessor bus master outputs
module tb_coprocessor_bus_master_outputs
    import cbm_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk_i = 0, reset_i = 1, req_valid_i = 0, ls_stall_i = 0, ls_flush_i = 0;
    logic addr_exc_i = 0, slow = 0, req_ready_o, bus_ready_i, flushed, stalled;
    cbm_req_t req_i = '0;
    logic [CMD_W-1:0] cmd;
    logic [REG_W-1:0] cpno, ra, rb, rc;
    logic [DATA_W-1:0] wa, wb;
    int bad_count = 0, samples_checked = 0, ops, k;
    always #10 clk_i = ~clk_i;
    cbm_master cbm_master_i(.clk_i(clk_i), .reset_i(reset_i), .req_valid_i(req_valid_i),
        .req_ready_o(req_ready_o), .req_i(req_i), .ls_stall_i(ls_stall_i),
        .ls_flush_i(ls_flush_i), .addr_exc_i(addr_exc_i), .bus_ready_i(bus_ready_i),
        .bus_cmd_o(cmd), .bus_cpno_o(cpno), .bus_rega_o(ra), .bus_regb_o(rb),
        .bus_regc_o(rc), .bus_wdataa_o(wa), .bus_wdatab_o(wb),
        .cpu_flushed_o(flushed), .cpu_stalled_o(stalled));
    cbm_slave_model cbm_slave_model_i(.clk_i(clk_i), .slow_i(slow), .bus_cmd_i(cmd),
        .cpu_stalled_i(stalled), .cpu_flushed_i(flushed), .bus_ready_o(bus_ready_i),
        .ops_o(ops));
    task automatic chk(input string n, input logic [63:0] e, input logic [63:0] g);
        samples_checked++;
        if (g !== e) begin
            bad_count++;
            $display("[FAIL] %s expected %0h seen %0h", n, e, g);
        end
    endtask
    task automatic results;
        if (bad_count == 0 && samples_checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask
    function automatic cbm_req_t mk(input cbm_kind_t kd, input logic [7:0] c,
        input logic [3:0] cp, d, s, x, y, input logic [7:0] sy, input logic [63:0] dt);
        cbm_req_t r;
        r = '{kd, c, cp, d, s, x, y, sy, dt};
        return r;
    endfunction
    // offer one request and wait until it stands on the bus
    task automatic issue(input cbm_req_t r);
        int i;
        req_i = r;
        req_valid_i = 1;
        for (i = 0; i < 20 && req_ready_o !== 1'b1; i++) step(1);
        if (i == 20) begin
            chk("req_ready_o", 1, 0);
            results;
        end
        step(1);
        req_valid_i = 0;
        step(1);
    endtask
    task automatic bus(input logic [6:0] m, input logic [7:0] c, input logic [3:0] n, a, b,
        cc, input logic [31:0] da, db);
        if (m[0]) chk("cmd", c, cmd);
        if (m[1]) chk("cpno", n, cpno);
        if (m[2]) chk("rega", a, ra);
        if (m[3]) chk("regb", b, rb);
        if (m[4]) chk("regc", cc, rc);
        if (m[5]) chk("wdataa", da, wa);
        if (m[6]) chk("wdatab", db, wb);
    endtask
    task automatic t_cop;
        slow = 1;
        issue(mk(CBM_COP, 8'h85, 4'h3, 4'h9, 4'h0, 4'h2, 4'hE, 8'h00, 64'h0));
        bus(7'h1F, 8'h85, 4'h3, 4'h9, 4'h2, 4'hE, 32'h0, 32'h0);
        for (k = 0; k < 2; k++) begin
            step(1);
            chk("held cmd", 8'h85, cmd);
            chk("stalled", 1, stalled);
        end
        step(2);
        chk("stalled", 0, stalled);
        chk("ops", 1, ops);
        slow = 0;
    endtask
    task automatic t_xfer;
        logic [7:0] sc[4];
        sc = '{CMD_MTSR, CMD_MFSR, CMD_MTDR, CMD_MFDR};
        issue(mk(CBM_DBL_WR, CMD_WRITE_D, 4'h0, 4'h6, 4'h0, 4'h0, 4'h0, 8'h0,
            64'h1122334455667788));
        bus(7'h6D, CMD_WRITE_D, 4'h0, 4'h7, 4'h6, 4'h0, 32'h11223344,
            32'h55667788);
        issue(mk(CBM_DBL_RD, CMD_READ_D, 4'h0, 4'h0, 4'hF, 4'h0, 4'h0, 8'h0, 64'h0));
        bus(7'h0D, CMD_READ_D, 4'h0, 4'h0, 4'hF, 4'h0, 32'h0, 32'h0);
        issue(mk(CBM_WORD_WR, CMD_WRITE_W, 4'h0, 4'hA, 4'h0, 4'h0, 4'h0, 8'h0, 64'h5CAFEF00D));
        bus(7'h25, CMD_WRITE_W, 4'h0, 4'hA, 4'h0, 4'h0, 32'hCAFEF00D, 32'h0);
        issue(mk(CBM_WORD_RD, CMD_READ_W, 4'h0, 4'h0, 4'h5, 4'h0, 4'h0, 8'h0, 64'h0));
        bus(7'h05, CMD_READ_W, 4'h0, 4'h5, 4'h0, 4'h0, 32'h0, 32'h0);
        for (k = 0; k < 4; k++) begin
            issue(mk(CBM_SYSREG, sc[k], 4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 8'hB4, 64'h0));
            bus(7'h07, sc[k], 4'hB, 4'h4, 4'h0, 4'h0, 32'h0, 32'h0);
        end
    endtask
    task automatic t_flags;
        ls_stall_i = 1;
        step(1);
        ls_stall_i = 0;
        chk("stalled", 1, stalled);
        step(1);
        chk("stalled", 0, stalled);
        ls_flush_i = 1;
        step(1);
        ls_flush_i = 0;
        chk("flushed", 1, flushed);
        step(1);
        chk("flushed", 0, flushed);
        addr_exc_i = 1;
        step(1);
        addr_exc_i = 0;
        chk("flushed", 1, flushed);
    endtask
    // fill the buffer under stall, drain it in order, then drop a head by flush
    task automatic t_fill;
        ls_stall_i = 1;
        req_i = mk(CBM_WORD_RD, CMD_READ_W, 4'h0, 4'h0, 4'h1, 4'h0, 4'h0, 8'h0, 64'h0);
        req_valid_i = 1;
        step(1);
        req_i.source_unit_reg = 4'h2;
        step(1);
        req_valid_i = 0;
        ls_stall_i = 0;
        chk("req_ready_o", 0, req_ready_o);
        step(1);
        bus(7'h05, CMD_READ_W, 4'h0, 4'h1, 4'h0, 4'h0, 32'h0, 32'h0);
        step(1);
        bus(7'h05, CMD_READ_W, 4'h0, 4'h2, 4'h0, 4'h0, 32'h0, 32'h0);
        req_valid_i = 1;
        step(1);
        req_valid_i = 0;
        ls_flush_i = 1;
        step(1);
        ls_flush_i = 0;
        chk("cmd", CMD_NOP, cmd);
        chk("flushed", 1, flushed);
    endtask
    initial begin
        step(2);
        reset_i = 0;
        t_xfer;
        t_cop;
        t_flags;
        t_fill;
        results;
    end
endmodule // tb_coprocessor_bus_master_outputs
